// *** design/asp_pkg.sv ***
// Overview of operation
// - Receive bit 8: stop bit or ninth bit
// - Receive bits 7-0: low data byte, true
// - Nonzero transmit word write fills the buffer, sent once the shifter is idle
// - Transmit uses the shared receive bit period
// - Load shift register and pulse buffer-empty event in the same cycle
// - One bit per period, least significant first
// - Stop at lone one bit, flag shifter empty
// - New nonzero word restarts the idle shifter
// - One start bit precedes data bit zero
// - All-zero transmit word write is ignored
// - Period bits 14-0 give N+1 color clocks
// - Period bit 15 selects nine-bit reception
// - Buffer-full shows word; overrun on second arrival
package asp_pkg;

    // =========================================================
    // Timing
    localparam int ASP_CLK_PERIOD_PS = 10000;
    localparam int ASP_COLOR_CLK_PS = 279400;
    localparam int ASP_COLOR_CYCLES_I =
        (ASP_COLOR_CLK_PS + ASP_CLK_PERIOD_PS / 2) / ASP_CLK_PERIOD_PS;
    localparam int ASP_PRE_W = 8;
    localparam logic [ASP_PRE_W-1:0] ASP_COLOR_CYCLES = ASP_COLOR_CYCLES_I[ASP_PRE_W-1:0];
    localparam int ASP_DIV_W = 15;

    // =========================================================
    // Chip register offsets
    localparam int ASP_ADDR_W = 9;
    localparam logic [ASP_ADDR_W-1:0] ASP_OFS_CTRL_READ = 9'h010;
    localparam logic [ASP_ADDR_W-1:0] ASP_OFS_CTRL_WRITE = 9'h09E;
    localparam logic [ASP_ADDR_W-1:0] ASP_OFS_RX_WORD = 9'h020;
    localparam logic [ASP_ADDR_W-1:0] ASP_OFS_TX_WORD = 9'h022;
    localparam logic [ASP_ADDR_W-1:0] ASP_OFS_PERIOD = 9'h024;

    // =========================================================
    // Field positions and reset values
    localparam int ASP_CTRL_SETCLR_BIT = 15;
    localparam int ASP_CTRL_BREAK_BIT = 11;
    localparam int ASP_PERIOD_NINE_BIT = 15;
    localparam int ASP_RX_OVERRUN_BIT = 15;
    localparam int ASP_RX_FULL_BIT = 14;
    localparam int ASP_RX_TBE_BIT = 13;
    localparam int ASP_RX_SHIFT_REGISTER_EMPTY_FLAG_BIT = 12;
    localparam int ASP_RX_PIN_BIT = 11;
    localparam int ASP_RX_STOP9_BIT = 9;
    localparam int ASP_RX_BIT8 = 8;
    localparam logic [15:0] ASP_CTRL_DATA_MASK = 16'h7FFF;
    localparam logic [15:0] ASP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ASP_PERIOD_RESET = 16'h0000;
    localparam logic [15:0] ASP_SR_LAST = 16'h0001;

    // =========================================================
    // Types
    typedef enum logic [2:0] {
        ASP_TX_IDLE = 3'b001,
        ASP_TX_START = 3'b010,
        ASP_TX_SHIFT = 3'b100
    } asp_tx_state_e;

    typedef struct packed {
        logic [ASP_ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } asp_bus_req_s;

    typedef struct packed {
        logic load;
        logic [8:0] data;
        logic stop;
    } asp_rx_word_s;

    typedef struct packed {
        logic [ASP_PRE_W-1:0] pre;
        logic [ASP_DIV_W-1:0] cnt;
        logic tick;
    } asp_timer_s;

    typedef struct packed {
        asp_tx_state_e tx_state;
        logic [15:0] hold;
        logic hold_full;
        logic [15:0] sr;
        logic txd;
        logic tbe_pulse;
        logic [15:0] ctrl;
        logic [15:0] period;
        logic [7:0] rx_low;
        logic rx_b8;
        logic rx_b9;
        logic receive_buffer_full_flag;
        logic ovr;
        logic [15:0] rdata;
    } asp_state_s;

endpackage

// *** design/asp_bit_timer.sv ***
`timescale 1ns/100ps
module asp_bit_timer import asp_pkg::*; #(
    parameter logic [ASP_PRE_W-1:0] COLOR_CYCLES = ASP_COLOR_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic [ASP_DIV_W-1:0] divisor,
    output logic tick
);

    asp_timer_s q;
    asp_timer_s d;

    // =========================================================
    // Color clock prescaler and N+1 divider
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (restart) begin
            d.pre = '0;
            d.cnt = '0;
        end else if (q.pre == COLOR_CYCLES - 8'h01) begin
            d.pre = '0;
            if (q.cnt >= divisor) begin
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 15'h0001;
            end
        end else begin
            d.pre = q.pre + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

// *** design/asp_serial_port.sv ***
`timescale 1ns/100ps
module asp_serial_port import asp_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire asp_bus_req_s bus,
    input wire asp_rx_word_s rx_word,
    input wire logic rx_restart,
    input wire logic rxd_pin,
    input wire logic rbf_clear,
    output logic txd,
    output logic [15:0] reg_rdata,
    output logic tbe_irq,
    output logic rbf_flag,
    output logic overrun_flag,
    output logic rx_sample_tick
);

    asp_state_s q;
    asp_state_s d;
    logic tx_tick;
    logic tx_load;
    logic rx_tick;

    // =========================================================
    // Set or clear update of the shared control word
    function automatic logic [15:0] asp_set_clear(input logic [15:0] cur,
                                                  input logic [15:0] wr);
        logic [15:0] bits;
        bits = wr & ASP_CTRL_DATA_MASK;
        if (wr[ASP_CTRL_SETCLR_BIT]) begin
            asp_set_clear = cur | bits;
        end else begin
            asp_set_clear = cur & ~bits;
        end
    endfunction

    function automatic logic asp_hit(input asp_bus_req_s b,
                                     input logic [ASP_ADDR_W-1:0] ofs);
        asp_hit = (b.addr == ofs);
    endfunction

    // =========================================================
    // Bit period timers, both fed by one period register
    // shared bit period
    asp_bit_timer u_tx_timer (
        .clk(clk),
        .rst_b(rst_b),
        .restart(tx_load),
        .divisor(q.period[ASP_DIV_W-1:0]),
        .tick(tx_tick)
    );

    asp_bit_timer u_rx_timer (
        .clk(clk),
        .rst_b(rst_b),
        .restart(rx_restart),
        .divisor(q.period[ASP_DIV_W-1:0]),
        .tick(rx_tick)
    );

    // =========================================================
    // Next state
    always_comb begin
        d = q;
        d.tbe_pulse = 1'b0;
        d.rdata = 16'h0000;
        tx_load = 1'b0;

        // Transmit sequencer, ahead of the register writes
        unique case (q.tx_state)
            ASP_TX_IDLE: begin
                if (q.hold_full) begin
                    tx_load = 1'b1;
                end
            end
            ASP_TX_START: begin
                if (tx_tick) begin
                    d.tx_state = ASP_TX_SHIFT;
                end
            end
            ASP_TX_SHIFT: begin
                if (tx_tick) begin
                    if (q.sr == ASP_SR_LAST) begin
                        if (q.hold_full) begin
                            tx_load = 1'b1;
                        end else begin
                            d.tx_state = ASP_TX_IDLE;
                        end
                    end else begin
                        d.sr = {1'b0, q.sr[15:1]};
                    end
                end
            end
        endcase

        if (tx_load) begin
            d.sr = q.hold;
            d.hold_full = 1'b0;
            d.tbe_pulse = 1'b1;
            d.tx_state = ASP_TX_START;
        end

        // Register writes
        if (bus.wr) begin
            if (asp_hit(bus, ASP_OFS_CTRL_WRITE)) begin
                d.ctrl = asp_set_clear(q.ctrl, bus.wdata);
            end
            if (asp_hit(bus, ASP_OFS_PERIOD)) begin
                d.period = bus.wdata;
            end
            if (asp_hit(bus, ASP_OFS_TX_WORD) && bus.wdata != 16'h0000) begin
                d.hold = bus.wdata;
                d.hold_full = 1'b1;
            end
        end

        // Receive buffer; a new word wins over a clear
        if (rx_word.load) begin
            d.rx_low = rx_word.data[7:0];
            if (q.period[ASP_PERIOD_NINE_BIT]) begin
                d.rx_b8 = rx_word.data[8];
                d.rx_b9 = rx_word.stop;
            end else begin
                d.rx_b8 = rx_word.stop;
                d.rx_b9 = 1'b0;
            end
            d.receive_buffer_full_flag = 1'b1;
            d.ovr = q.ovr | q.receive_buffer_full_flag;
        end else if (rbf_clear) begin
            d.receive_buffer_full_flag = 1'b0;
            d.ovr = 1'b0;
        end

        // Register reads, one cycle later on reg_rdata
        if (bus.rd) begin
            if (asp_hit(bus, ASP_OFS_CTRL_READ)) begin
                d.rdata = q.ctrl & ASP_CTRL_DATA_MASK;
            end else if (asp_hit(bus, ASP_OFS_RX_WORD)) begin
                d.rdata[7:0] = q.rx_low;
                d.rdata[ASP_RX_BIT8] = q.rx_b8;
                d.rdata[ASP_RX_STOP9_BIT] = q.rx_b9;
                d.rdata[ASP_RX_PIN_BIT] = rxd_pin;
                d.rdata[ASP_RX_SHIFT_REGISTER_EMPTY_FLAG_BIT] = (q.tx_state == ASP_TX_IDLE);
                d.rdata[ASP_RX_TBE_BIT] = !q.hold_full;
                d.rdata[ASP_RX_FULL_BIT] = q.receive_buffer_full_flag;
                d.rdata[ASP_RX_OVERRUN_BIT] = q.ovr;
            end
        end

        // Line level from the state about to be entered
        if (d.ctrl[ASP_CTRL_BREAK_BIT]) begin
            d.txd = 1'b0;
        end else if (d.tx_state == ASP_TX_START) begin
            d.txd = 1'b0;
        end else if (d.tx_state == ASP_TX_SHIFT) begin
            d.txd = d.sr[0];
        end else begin
            d.txd = 1'b1;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.tx_state <= ASP_TX_IDLE;
            q.txd <= 1'b1;
            q.ctrl <= ASP_CTRL_RESET;
            q.period <= ASP_PERIOD_RESET;
        end else begin
            q <= d;
        end
    end

    assign txd = q.txd;
    assign reg_rdata = q.rdata;
    assign tbe_irq = q.tbe_pulse;
    assign rbf_flag = q.receive_buffer_full_flag;
    assign overrun_flag = q.ovr;
    assign rx_sample_tick = rx_tick;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_tx_write_nonzero;
        bus.wr && asp_hit(bus, ASP_OFS_TX_WORD) && bus.wdata != 16'h0000;
    endsequence

    sequence s_tx_write_zero;
        bus.wr && asp_hit(bus, ASP_OFS_TX_WORD) && bus.wdata == 16'h0000;
    endsequence

    sequence s_idle_empty;
        q.tx_state == ASP_TX_IDLE && !q.hold_full;
    endsequence

    sequence s_load_seen;
        q.tx_state == ASP_TX_START && tbe_irq;
    endsequence

    sequence s_last_bit_done;
        q.tx_state == ASP_TX_SHIFT && q.sr == ASP_SR_LAST && tx_tick && !q.hold_full;
    endsequence

    AST_TX_WRITE_STARTS: assert property (
        (s_tx_write_nonzero and s_idle_empty) |=> q.hold_full ##1 s_load_seen)
        else $error("Nonzero transmit write did not start");

    AST_TX_ZERO_IGNORED: assert property (
        (s_tx_write_zero and s_idle_empty) |=> !q.hold_full ##1 !tbe_irq)
        else $error("Zero transmit write started a frame");

    AST_TBE_AFTER_COPY: assert property (
        (q.tx_state == ASP_TX_IDLE && q.hold_full) |=>
            (s_load_seen and (q.sr == $past(q.hold)) and !q.hold_full))
        else $error("Buffer-empty event not tied to shift load");

    AST_START_LOW: assert property (
        q.tx_state == ASP_TX_START |-> !txd)
        else $error("Start bit not low");

    AST_SHIFT_LSB: assert property (
        (q.tx_state == ASP_TX_SHIFT && !q.ctrl[ASP_CTRL_BREAK_BIT]) |-> txd == q.sr[0])
        else $error("Line does not carry shifter bit zero");

    AST_SHIFT_STEP: assert property (
        (q.tx_state == ASP_TX_SHIFT && tx_tick && q.sr != ASP_SR_LAST) |=>
            q.sr == {1'b0, $past(q.sr[15:1])})
        else $error("Shifter did not step one place");

    AST_STOP_EMPTY: assert property (
        s_last_bit_done |=> q.tx_state == ASP_TX_IDLE ##1
            (reg_rdata[ASP_RX_SHIFT_REGISTER_EMPTY_FLAG_BIT] || !$past(bus.rd && asp_hit(bus, ASP_OFS_RX_WORD))))
        else $error("Shifter did not stop on lone one");

    AST_BREAK_LOW: assert property (
        q.ctrl[ASP_CTRL_BREAK_BIT] |-> !txd)
        else $error("Break set but line not low");

    AST_IDLE_MARK: assert property (
        (q.tx_state == ASP_TX_IDLE && !q.ctrl[ASP_CTRL_BREAK_BIT]) |-> txd)
        else $error("Idle line not at mark");

    AST_CTRL_SET: assert property (
        (bus.wr && asp_hit(bus, ASP_OFS_CTRL_WRITE) && bus.wdata[ASP_CTRL_SETCLR_BIT]) |=>
            (q.ctrl & ($past(bus.wdata) & ASP_CTRL_DATA_MASK)) ==
                ($past(bus.wdata) & ASP_CTRL_DATA_MASK))
        else $error("Set write did not set bits");

    AST_CTRL_CLEAR: assert property (
        (bus.wr && asp_hit(bus, ASP_OFS_CTRL_WRITE) && !bus.wdata[ASP_CTRL_SETCLR_BIT]) |=>
            (q.ctrl & ($past(bus.wdata) & ASP_CTRL_DATA_MASK)) == 16'h0000)
        else $error("Clear write did not clear bits");

    AST_RX_LOW_BYTE: assert property (
        rx_word.load |=> q.rx_low == $past(rx_word.data[7:0]))
        else $error("Received low byte wrong");

    AST_RX_BIT8_MODE: assert property (
        rx_word.load |=> q.rx_b8 ==
            ($past(q.period[ASP_PERIOD_NINE_BIT]) ? $past(rx_word.data[8]) : $past(rx_word.stop)))
        else $error("Receive bit 8 does not follow mode");

    AST_RX_OVERRUN: assert property (
        (rx_word.load && q.receive_buffer_full_flag) |=> q.ovr && q.receive_buffer_full_flag)
        else $error("Second word did not flag overrun");

    AST_TX_BACK_TO_BACK: assert property (
        (q.tx_state == ASP_TX_SHIFT && q.sr == ASP_SR_LAST && tx_tick && q.hold_full) |=>
            s_load_seen)
        else $error("Waiting word did not restart the shifter");

    AST_TBE_ONE_CYCLE: assert property (
        tbe_irq |=> !tbe_irq)
        else $error("Buffer-empty event longer than one cycle");

    AST_RX_CLEAR: assert property (
        (rbf_clear && !rx_word.load) |=> !q.receive_buffer_full_flag && !q.ovr)
        else $error("Clear did not drop buffer-full and overrun");

    AST_RX_BIT9_MODE: assert property (
        rx_word.load |=> q.rx_b9 ==
            ($past(q.period[ASP_PERIOD_NINE_BIT]) && $past(rx_word.stop)))
        else $error("Receive bit 9 does not follow mode");

    AST_RX_READ_BACK: assert property (
        (bus.rd && asp_hit(bus, ASP_OFS_RX_WORD)) |=>
            reg_rdata[7:0] == $past(q.rx_low) && reg_rdata[ASP_RX_BIT8] == $past(q.rx_b8))
        else $error("Receive word read back wrong");

endmodule

// *** tb/asp_peer.sv ***
`timescale 1ns/100ps
// ====
// Far-end peripheral: samples the line mid-bit
module asp_peer import asp_pkg::*; (
    input wire logic clk,
    input wire logic line,
    input wire logic [15:0] bit_cycles,
    output logic rxd,
    output logic [15:0] word,
    output logic [7:0] frames
);
    initial begin
        rxd = 1'b1;
        word = 16'h0000;
        frames = 8'h00;
        forever begin
            @(negedge line);
            repeat (bit_cycles / 2) @(posedge clk);
            if (line === 1'b0) begin
                for (int i = 0; i < 9; i++) begin
                    repeat (bit_cycles) @(posedge clk);
                    word[i] = line;
                end
                frames = frames + 8'h01;
            end
        end
    end
endmodule

// *** tb/asp_serial_port_tb_top.sv ***
`timescale 1ns/100ps
module asp_serial_port_tb_top import asp_pkg::*; ;
    localparam int BIT_CYC = 2 * ASP_COLOR_CYCLES_I;
    logic clk = 1'b0;
    logic rst_b, rx_restart, rbf_clear, rxd_pin;
    asp_bus_req_s bus;
    asp_rx_word_s rx_word;
    logic txd, tbe_irq, rbf_flag, overrun_flag, rx_sample_tick;
    logic [15:0] reg_rdata, peer_word;
    logic [7:0] peer_frames;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    asp_serial_port dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rx_word(rx_word),
        .rx_restart(rx_restart), .rxd_pin(rxd_pin), .rbf_clear(rbf_clear), .txd(txd),
        .reg_rdata(reg_rdata), .tbe_irq(tbe_irq), .rbf_flag(rbf_flag),
        .overrun_flag(overrun_flag), .rx_sample_tick(rx_sample_tick));

    asp_peer peer (.clk(clk), .line(txd), .bit_cycles(16'(BIT_CYC)), .rxd(rxd_pin),
        .word(peer_word), .frames(peer_frames));

    // ====
    // Shared tasks
    task automatic test_done;
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ASP_ADDR_W-1:0] a, input logic [15:0] d);
        @(negedge clk);
        bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(negedge clk);
        bus.wr = 1'b0;
    endtask

    task automatic rd(input logic [ASP_ADDR_W-1:0] a, output logic [15:0] v);
        @(negedge clk);
        bus.addr = a;
        bus.rd = 1'b1;
        @(negedge clk);
        bus.rd = 1'b0;
        v = reg_rdata;
    endtask

    task automatic rd_chk(input logic [ASP_ADDR_W-1:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    task automatic load(input logic [8:0] d, input logic s);
        @(negedge clk);
        rx_word = '{load: 1'b1, data: d, stop: s};
        @(negedge clk);
        rx_word.load = 1'b0;
    endtask

    task automatic clr;
        chk({14'h0, overrun_flag, rbf_flag}, 16'h0003);
        @(negedge clk);
        rbf_clear = 1'b1;
        @(negedge clk);
        rbf_clear = 1'b0;
        @(negedge clk);
        chk({14'h0, overrun_flag, rbf_flag}, 16'h0000);
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (tbe_irq !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 8), 16'h0001);
    endtask

    task automatic wait_frame(input logic [7:0] f);
        int n;
        n = 0;
        while (peer_frames === f && n < 20 * BIT_CYC) begin
            @(negedge clk);
            n++;
        end
    endtask

    // ====
    // Scenarios
    task automatic t_reset;
        rd_chk(ASP_OFS_RX_WORD, 16'h3800);
        rd_chk(ASP_OFS_PERIOD, 16'h0000);
        rd_chk(ASP_OFS_TX_WORD, 16'h0000);
        rd_chk(9'h1FE, 16'h0000);
        rd_chk(ASP_OFS_CTRL_READ, 16'h0000);
        chk({15'h0, txd}, 16'h0001);
    endtask

    task automatic t_zero;
        int seen;
        seen = 0;
        wr(ASP_OFS_TX_WORD, 16'h0000);
        repeat (3 * BIT_CYC) begin
            @(negedge clk);
            if (tbe_irq !== 1'b0 || txd !== 1'b1) seen++;
        end
        chk(16'(seen), 16'h0000);
        rd_chk(ASP_OFS_RX_WORD, 16'h3800);
    endtask

    task automatic t_tx;
        logic [7:0] f;
        logic [15:0] v;
        int n;
        wr(ASP_OFS_PERIOD, 16'h0001);
        f = peer_frames;
        wr(ASP_OFS_TX_WORD, 16'h0155);
        wait_irq;
        wr(ASP_OFS_TX_WORD, 16'h03CA);
        rd(ASP_OFS_RX_WORD, v);
        chk(v & 16'h3000, 16'h0000);
        wait_frame(f);
        chk(peer_word, 16'h0155);
        wait_frame(f + 8'h01);
        chk(peer_word, 16'h01CA);
        n = 0;
        v = 16'h0000;
        while (v[ASP_RX_SHIFT_REGISTER_EMPTY_FLAG_BIT] !== 1'b1 && n < 100) begin
            rd(ASP_OFS_RX_WORD, v);
            n++;
        end
        chk(v, 16'h3800);
        chk({15'h0, txd}, 16'h0001);
    endtask

    task automatic t_rx;
        load(9'h1A5, 1'b1);
        rd_chk(ASP_OFS_RX_WORD, 16'h79A5);
        load(9'h0F0, 1'b0);
        rd_chk(ASP_OFS_RX_WORD, 16'hF8F0);
        clr;
        wr(ASP_OFS_PERIOD, 16'h8001);
        load(9'h0A5, 1'b1);
        rd_chk(ASP_OFS_RX_WORD, 16'h7AA5);
        load(9'h13C, 1'b0);
        rd_chk(ASP_OFS_RX_WORD, 16'hF93C);
        clr;
        wr(ASP_OFS_PERIOD, 16'h0001);
    endtask

    task automatic t_ctrl;
        wr(ASP_OFS_CTRL_WRITE, 16'h8803);
        @(negedge clk);
        chk({15'h0, txd}, 16'h0000);
        rd_chk(ASP_OFS_CTRL_READ, 16'h0803);
        wr(ASP_OFS_CTRL_WRITE, 16'h0801);
        rd_chk(ASP_OFS_CTRL_READ, 16'h0002);
        chk({15'h0, txd}, 16'h0001);
        wr(ASP_OFS_CTRL_READ, 16'h8001);
        wr(ASP_OFS_CTRL_WRITE, 16'h0002);
        rd_chk(ASP_OFS_CTRL_READ, 16'h0000);
    endtask

    task automatic t_tick;
        int n;
        @(negedge clk);
        rx_restart = 1'b1;
        @(negedge clk);
        rx_restart = 1'b0;
        n = 0;
        while (rx_sample_tick !== 1'b1 && n < 4 * BIT_CYC) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rx_sample_tick !== 1'b1 && n < 4 * BIT_CYC);
        chk(16'(n), 16'(BIT_CYC));
    endtask

    // ====
    // Main sequence and watchdog
    initial begin
        rst_b = 1'b0;
        bus = '0;
        rx_word = '0;
        rx_restart = 1'b0;
        rbf_clear = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_zero;
        t_tx;
        t_rx;
        t_ctrl;
        t_tick;
        test_done;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done;
        end
    end
endmodule
